// ==== rtl/sca_card.sv ====
// card end: answer-to-reset sender and power selection tracking
// assumes: terminal drives vcc, rst and link clock; no own clock on link
`timescale 1ns/100ps
`include "sca_params.svh"

module sca_card #(
	parameter logic [2:0]  CLASS_MASK = 3'h6,   // supported classes
	parameter logic [7:0]  FD         = 8'h94,  // advertised rate pair
	parameter logic [8:0]  ETU        = `SCA_ETU_DEFAULT,
	parameter logic [7:0]  CDS        = 8'ha0,  // card data service value
	parameter logic [23:0] CAP        = 24'h0   // card capabilities value
) (
	input  wire logic              clk,         // system clock
	input  wire logic              arst_n,      // async reset
	sca_if.card                    lnk,         // link pins
	input  wire logic              cmd_valid,   // command executed
	input  wire sca_pkg::sca_cmd_t cmd_kind,    // command class
	input  wire logic              app_has_ac,  // app needs access condition
	input  wire logic              mute,        // send no answer
	input  wire logic              truncate,    // send a cut answer
	input  wire logic [7:0]        tx_data,     // user byte
	input  wire logic              tx_valid,    // user send request
	output logic                   tx_ready,    // user byte taken
	output logic [7:0]             rx_data,     // byte from terminal
	output logic                   rx_valid,    // byte pulse
	output logic                   atr_done,    // last answer byte taken by sender
	output logic                   high_power   // application selected
);
	sca_pkg::sca_card_t s;
	sca_pkg::sca_card_t n;
	logic               tick;
	logic               live;
	logic               s_ready;
	logic               s_valid;
	logic [7:0]         s_data;
	logic               drive_low;
	logic [3:0]         last;
	logic [7:0]         fd_adv;

	// fixed answer bytes, check byte comes from the running xor
	function automatic logic [7:0] atr_byte(input logic [3:0] i, input logic [7:0] fd_v);
		unique case (i)
			4'h0: return `SCA_TS_DIRECT;
			4'h1: return {`SCA_T0_Y, `SCA_HIST_LEN};
			4'h2: return fd_v;
			4'h3: return `SCA_TD1_BYTE;
			4'h4: return `SCA_TD2_BYTE;
			4'h5: return {5'h0, sca_pkg::adjacent_set(CLASS_MASK)};
			4'h6: return `SCA_HIST_CAT;
			4'h7: return `SCA_TAG_CDS;
			4'h8: return CDS;
			4'h9: return `SCA_TAG_CAP;
			4'ha: return CAP[23:16];
			4'hb: return CAP[15:8];
			4'hc: return CAP[7:0];
			default: return 8'h0;
		endcase
	endfunction: atr_byte

	// divisor 64 only with the 512 clock factor
	assign fd_adv = (FD[3:0] != `SCA_DI_64 || FD[7:4] == `SCA_FI_512) ? FD : `SCA_FD_DEFAULT;
	assign last   = truncate ? `SCA_ATR_CUT : `SCA_ATR_LAST;
	assign tick   = s.lclk_s2 & ~s.lclk_s3;
	assign live   = s.pwr_s2 & s.rst_s2;

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		n = s;
		n.lclk_s1 = lnk.lclk;
		n.lclk_s2 = s.lclk_s1;
		n.lclk_s3 = s.lclk_s2;
		n.rst_s1 = lnk.rst;
		n.rst_s2 = s.rst_s1;
		n.io_s1 = lnk.io;
		n.io_s2 = s.io_s1;
		n.pwr_s1 = |lnk.vcc;
		n.pwr_s2 = s.pwr_s1;
		s_valid = 1'b0;
		s_data = tx_data;
		unique case (s.st)
			sca_pkg::C_OFF: begin
				n.st = sca_pkg::C_WAIT;
				n.cnt = `SCA_ATR_DELAY;
			end
			sca_pkg::C_WAIT: begin
				if (tick && s.cnt != 10'h0)
					n.cnt = s.cnt - 10'h1;
				if (s.cnt == 10'h0 && !mute) begin
					n.st = sca_pkg::C_ATR;
					n.idx = 4'h0;
					n.xacc = 8'h0;
				end
			end
			sca_pkg::C_ATR: begin
				// nothing else leaves the card before the answer
				s_valid = 1'b1;
				s_data = (s.idx == `SCA_ATR_LAST) ? s.xacc : atr_byte(s.idx, fd_adv);
				if (s_ready) begin
					n.idx = s.idx + 4'h1;
					n.xacc = (s.idx == 4'h0) ? 8'h0 : s.xacc ^ s_data;
					if (s.idx == last)
						n.st = sca_pkg::C_RUN;
				end
			end
			sca_pkg::C_RUN: begin
				s_valid = tx_valid;
			end
		endcase
		// selection bookkeeping for the power limit
		if (cmd_valid) begin
			unique case (cmd_kind)
				sca_pkg::CMD_SELECT:    n.sel = 1'b0;
				sca_pkg::CMD_STATUS:    n.sel = s.sel;
				sca_pkg::CMD_VERIFY_OK: n.sel = s.sel | app_has_ac;
				sca_pkg::CMD_APP:       n.sel = s.sel | !app_has_ac;
			endcase
		end
		if (!live) begin
			n.st = sca_pkg::C_OFF;
			n.sel = 1'b0;
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			s <= '0;
		else
			s <= n;
	end

	sca_ser #(
		.ETU       (ETU)
	) u_ser (
		.clk       (clk),
		.arst_n    (arst_n),
		.tick      (tick),
		.rx_in     (s.io_s2),
		.tx_data   (s_data),
		.tx_valid  (s_valid && live),
		.tx_ready  (s_ready),
		.drive_low (drive_low),
		.rx_data   (rx_data),
		.rx_valid  (rx_valid)
	);

	assign lnk.io_c_o    = 1'b0;
	assign lnk.io_c_oe_n = ~drive_low;
	assign tx_ready      = s_ready && s.st == sca_pkg::C_RUN;
	assign atr_done      = s.st == sca_pkg::C_RUN;
	assign high_power    = s.sel;
endmodule: sca_card

// ==== rtl/sca_ser.sv ====
// character serialiser/deserialiser on the io line
// assumes: tick is one clk pulse per link clock, rx_in already synchronised
`timescale 1ns/100ps
`include "sca_params.svh"

module sca_ser #(
	parameter logic [8:0] ETU = `SCA_ETU_DEFAULT
) (
	input  wire logic       clk,       // system clock
	input  wire logic       arst_n,    // async reset
	input  wire logic       tick,      // link clock pulse
	input  wire logic       rx_in,     // sampled io level
	input  wire logic [7:0] tx_data,   // byte to send
	input  wire logic       tx_valid,  // send request
	output logic            tx_ready,  // sender idle
	output logic            drive_low, // pull io low
	output logic [7:0]      rx_data,   // received byte
	output logic            rx_valid   // received pulse
);
	sca_pkg::sca_ser_t s;
	sca_pkg::sca_ser_t n;

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		n = s;
		n.rx_valid = 1'b0;
		if (tick) begin
			if (s.tx_busy) begin
				if (s.tx_cnt == 9'h0) begin
					n.tx_cnt = ETU - 9'h1;
					n.tx_sh = {1'b1, s.tx_sh[9:1]};
					n.tx_bit = s.tx_bit + 4'h1;
					n.tx_busy = s.tx_bit != 4'h9;
				end else begin
					n.tx_cnt = s.tx_cnt - 9'h1;
				end
			end
			// no start detection while own frame is out
			if (!s.rx_busy) begin
				if (!s.tx_busy && !rx_in) begin
					n.rx_busy = 1'b1;
					n.rx_cnt = ETU >> 1;
					n.rx_bit = 4'h0;
				end
			end else if (s.rx_cnt == 9'h0) begin
				n.rx_cnt = ETU - 9'h1;
				n.rx_bit = s.rx_bit + 4'h1;
				if (s.rx_bit == 4'h0) begin
					n.rx_busy = !rx_in; // glitch, not a start
				end else if (s.rx_bit == 4'h9) begin
					n.rx_busy = 1'b0;
					n.rx_data = rx_in ? s.rx_sh : s.rx_data;
					n.rx_valid = rx_in;
				end else begin
					n.rx_sh = {rx_in, s.rx_sh[7:1]};
				end
			end else begin
				n.rx_cnt = s.rx_cnt - 9'h1;
			end
		end
		if (tx_valid && !s.tx_busy) begin
			n.tx_busy = 1'b1;
			n.tx_sh = {1'b1, tx_data, 1'b0};
			n.tx_bit = 4'h0;
			n.tx_cnt = ETU - 9'h1;
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			s <= '0;
		else
			s <= n;
	end

	assign tx_ready  = !s.tx_busy;
	assign drive_low = s.tx_busy & ~s.tx_sh[0];
	assign rx_data   = s.rx_data;
	assign rx_valid  = s.rx_valid;
endmodule: sca_ser

// ==== rtl/sca_term.sv ====
// terminal end: supply class selection, activation retries, answer parsing
// assumes: card end on the other side of sca_if, pull-up on io
`timescale 1ns/100ps
`include "sca_params.svh"

module sca_term #(
	parameter logic [2:0] TERM_CLASSES   = 3'h7,    // classes the terminal can supply
	parameter int         DIV_HALF       = 4,       // half link clock in clk cycles
	parameter logic [8:0] ETU            = `SCA_ETU_DEFAULT,
	parameter int         ATR_WAIT_CLKS  = 320000,  // wait for first answer byte
	parameter int         CHAR_WAIT_CLKS = 100000,  // wait between answer bytes
	parameter int         OFF_CLKS       = 1000,    // power-off time between tries
	parameter bit         DI64_OK        = 1'b0     // divisor 64 supported
) (
	input  wire logic        clk,          // system clock
	input  wire logic        arst_n,       // async reset
	sca_if.term              lnk,          // link pins
	input  wire logic        start,        // activate card
	input  wire logic        stop,         // deactivate card
	input  wire logic [7:0]  tx_data,      // command byte
	input  wire logic        tx_valid,     // send request
	output logic             tx_ready,     // byte taken
	output logic [7:0]       rx_data,      // byte from card
	output logic             rx_valid,     // byte pulse
	output logic             ready,        // session open
	output logic             rejected,     // card given up
	output sca_pkg::sca_cls_t cls_used,    // class in use
	output sca_pkg::sca_cls_t card_classes,// classes card reports
	output logic [7:0]       fd,           // advertised rate pair
	output logic             pps_needed    // pair needs negotiation
);
	localparam logic [19:0] RST_LOW   = 20'(`SCA_RST_LOW_LCLK * 2 * DIV_HALF);
	localparam logic [19:0] ATR_WAIT  = 20'(ATR_WAIT_CLKS);
	localparam logic [19:0] CHAR_WAIT = 20'(CHAR_WAIT_CLKS);
	localparam logic [19:0] OFF_TIME  = 20'(OFF_CLKS);
	localparam logic [7:0]  DIV_LAST  = 8'(DIV_HALF - 1);

	sca_pkg::sca_term_t s;
	sca_pkg::sca_term_t n;
	sca_pkg::sca_cls_t  nh;
	sca_pkg::sca_cls_t  alt;
	logic               tick;
	logic               s_ready;
	logic               drive_low;
	logic [7:0]         b;
	logic               rxv;
	logic               go_bad;
	logic               go_none;
	logic               go_good;

	assign tick = (s.vcc != 3'h0) && s.div == DIV_LAST && !s.lclk;

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		n = s;
		nh = sca_pkg::next_higher(s.cls) & TERM_CLASSES;
		alt = 3'h0;
		go_bad = 1'b0;
		go_none = 1'b0;
		go_good = 1'b0;
		n.io_s1 = lnk.io;
		n.io_s2 = s.io_s1;
		n.tmr = (s.tmr != 20'h0) ? s.tmr - 20'h1 : 20'h0;
		// link clock runs only while the card is powered
		if (s.vcc != 3'h0) begin
			n.div = (s.div == DIV_LAST) ? 8'h0 : s.div + 8'h1;
			n.lclk = (s.div == DIV_LAST) ? ~s.lclk : s.lclk;
		end else begin
			n.div = 8'h0;
			n.lclk = 1'b0;
		end
		unique case (s.st)
			sca_pkg::T_IDLE, sca_pkg::T_READY, sca_pkg::T_REJECT: begin
				if (start) begin
					n.cls = sca_pkg::lowest_class(TERM_CLASSES);
					n.tries = 2'h0;
					n.st = (n.cls != 3'h0) ? sca_pkg::T_COLD : sca_pkg::T_REJECT;
					n.tmr = RST_LOW;
				end
			end
			sca_pkg::T_COLD: begin
				if (s.tmr == 20'h0) begin
					n.st = sca_pkg::T_ATR;
					n.tmr = ATR_WAIT;
					n.ph = sca_pkg::P_TS;
					n.pend = 4'h0;
					n.lvl = 3'h0;
					n.k = 4'h0;
					n.tck_need = 1'b0;
					n.in15 = 1'b0;
					n.cls_seen = 1'b0;
					n.card_cls = 3'h0;
					n.ta1 = `SCA_FD_DEFAULT;
					n.xacc = 8'h0;
					n.got = 1'b0;
					n.bad = 1'b0;
				end
			end
			sca_pkg::T_ATR: begin
				if (rxv) begin
					n.got = 1'b1;
					n.tmr = CHAR_WAIT;
					n.xacc = (s.ph == sca_pkg::P_TS) ? 8'h0 : s.xacc ^ b;
					unique case (s.ph)
						sca_pkg::P_TS: begin
							n.bad = b != `SCA_TS_DIRECT && b != `SCA_TS_INVERSE;
							n.ph = n.bad ? sca_pkg::P_END : sca_pkg::P_IF;
							n.pend = 4'h8;
						end
						sca_pkg::P_IF: begin
							// unused interface bytes are taken and dropped
							if (s.pend[0]) begin
								n.pend[0] = 1'b0;
								if (s.lvl == 3'h1)
									n.ta1 = b;
								if (s.in15 && !s.cls_seen) begin
									n.card_cls = b[2:0];
									n.cls_seen = 1'b1;
								end
							end else if (s.pend[1]) begin
								n.pend[1] = 1'b0;
							end else if (s.pend[2]) begin
								n.pend[2] = 1'b0;
							end else begin
								n.pend = b[7:4];
								n.lvl = s.lvl + 3'h1;
								n.in15 = s.lvl != 3'h0 && b[3:0] == `SCA_T15;
								if (s.lvl == 3'h0)
									n.k = b[3:0];
								else if (b[3:0] != 4'h0)
									n.tck_need = 1'b1;
							end
							if (n.pend == 4'h0)
								n.ph = (n.k != 4'h0) ? sca_pkg::P_HIST :
									(n.tck_need ? sca_pkg::P_TCK : sca_pkg::P_END);
						end
						sca_pkg::P_HIST: begin
							n.k = s.k - 4'h1;
							if (n.k == 4'h0)
								n.ph = s.tck_need ? sca_pkg::P_TCK : sca_pkg::P_END;
						end
						sca_pkg::P_TCK: begin
							n.ph = sca_pkg::P_END;
							n.bad = n.xacc != 8'h0;
						end
						sca_pkg::P_END: begin
						end
						default: n.ph = sca_pkg::P_END;
					endcase
				end
				if (!rxv && s.tmr == 20'h0) begin
					go_bad = s.got;
					go_none = !s.got;
				end else if (rxv && n.ph == sca_pkg::P_END) begin
					go_bad = n.bad;
					go_good = !n.bad;
				end
			end
			sca_pkg::T_OFF: begin
				if (s.tmr == 20'h0) begin
					n.st = sca_pkg::T_COLD;
					n.tmr = RST_LOW;
				end
			end
			default: n.st = sca_pkg::T_IDLE;
		endcase
		// outcome of one activation
		if (go_none) begin
			n.st = (nh != 3'h0) ? sca_pkg::T_OFF : sca_pkg::T_REJECT;
			n.cls = (nh != 3'h0) ? nh : s.cls;
			n.tries = 2'h0;
			n.tmr = OFF_TIME;
		end else if (go_bad) begin
			n.tmr = OFF_TIME;
			if (s.tries + 2'h1 != `SCA_BAD_MAX) begin
				n.tries = s.tries + 2'h1;
				n.st = sca_pkg::T_OFF;
			end else if (nh != 3'h0) begin
				n.cls = nh;
				n.tries = 2'h0;
				n.st = sca_pkg::T_OFF;
			end else begin
				n.st = sca_pkg::T_REJECT;
			end
		end else if (go_good) begin
			n.tries = 2'h0;
			n.tmr = OFF_TIME;
			if (n.cls_seen && (n.card_cls & s.cls) == 3'h0) begin
				alt = sca_pkg::lowest_class(n.card_cls & TERM_CLASSES);
				n.cls = (alt != 3'h0) ? alt : s.cls;
				n.st = (alt != 3'h0) ? sca_pkg::T_OFF : sca_pkg::T_REJECT;
			end else begin
				n.st = sca_pkg::T_READY;
				n.pps_needed = !sca_pkg::fd_ok(n.ta1, DI64_OK);
			end
		end
		if (stop)
			n.st = sca_pkg::T_IDLE;
		n.rst_pin = n.st == sca_pkg::T_ATR || n.st == sca_pkg::T_READY;
		n.vcc = (n.st == sca_pkg::T_COLD || n.rst_pin) ? n.cls : 3'h0;
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			s <= '0;
		else
			s <= n;
	end

	sca_ser #(
		.ETU       (ETU)
	) u_ser (
		.clk       (clk),
		.arst_n    (arst_n),
		.tick      (tick),
		.rx_in     (s.io_s2),
		.tx_data   (tx_data),
		.tx_valid  (tx_valid && ready),
		.tx_ready  (s_ready),
		.drive_low (drive_low),
		.rx_data   (b),
		.rx_valid  (rxv)
	);

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign lnk.lclk      = s.lclk;
	assign lnk.rst       = s.rst_pin;
	assign lnk.vcc       = s.vcc;
	assign lnk.io_t_o    = 1'b0;
	assign lnk.io_t_oe_n = ~drive_low;
	assign ready         = s.st == sca_pkg::T_READY;
	assign tx_ready      = s_ready && ready;
	assign rx_data       = b;   // select/status responses carry power need
	assign rx_valid      = rxv;
	assign rejected      = s.st == sca_pkg::T_REJECT;
	assign cls_used      = s.cls;
	assign card_classes  = s.card_cls;
	assign fd            = s.ta1;
	assign pps_needed    = s.pps_needed;
endmodule: sca_term

// ==== shared/sca_if.sv ====
// link between terminal end and card end
// assumes: pull-up on io, both ends open drain
`timescale 1ns/100ps

interface sca_if;
	logic       lclk;      // link clock from terminal
	logic       rst;       // card reset, low active on the wire
	logic [2:0] vcc;       // applied supply class, one hot, zero = off
	logic       io_t_o;    // terminal io drive value
	logic       io_t_oe_n; // terminal io enable, low drives
	logic       io_c_o;    // card io drive value
	logic       io_c_oe_n; // card io enable, low drives
	logic       io;        // resolved io level

	// pulled-up wire, any enabled low driver wins
	assign io = (io_t_oe_n | io_t_o) & (io_c_oe_n | io_c_o);

	modport term (output lclk, rst, vcc, io_t_o, io_t_oe_n, input io);
	modport card (input lclk, rst, vcc, io, output io_c_o, io_c_oe_n);
endinterface: sca_if

// ==== shared/sca_params.svh ====
// constants for the supply-class and answer-to-reset link setup
// assumes: included by the package and by every rtl file
//
// Overview of operation
// - Finish class switching before other activity
// - First activation at lowest supported class
// - No answer: deactivate, retry next higher class
// - Class unsupported by card: use advertised class
// - Corrupt answer: three tries at same class
// - After three corrupt: only next higher class
// - Class mask in first TA after T15
// - Reported class set must be adjacent
// - Low power until application is selected
// - Select then status is not selection
// - Power need comes from select/status response
// - Answer-to-reset is first string after reset
// - Accept foreign interface bytes, history, check byte
// - Answer always carries T15 global bytes
// - First historical byte is category 80
// - History objects: tag 31, then 73
// - Support (372,1), (512,8), (512,16) on both sides
// - Rate factors in TA1, else negotiate
// - Divisor code 0111 only with 1001
// - Reject after no answer or three bad answers at highest class
`ifndef SCA_PARAMS_SVH
`define SCA_PARAMS_SVH

// ----------------------------------------------------------------
// answer-to-reset fields
// ----------------------------------------------------------------
`define SCA_TS_DIRECT   8'h3b
`define SCA_TS_INVERSE  8'h3f
`define SCA_TD1_BYTE    8'h80
`define SCA_TD2_BYTE    8'h1f
`define SCA_T15         4'hf
`define SCA_HIST_LEN    4'h7
`define SCA_T0_Y        4'h9
`define SCA_HIST_CAT    8'h80
`define SCA_TAG_CDS     8'h31
`define SCA_TAG_CAP     8'h73
`define SCA_ATR_LAST    4'hd
`define SCA_ATR_CUT     4'h4

// ----------------------------------------------------------------
// class bits and rate factor codes
// ----------------------------------------------------------------
`define SCA_CLS_A       0
`define SCA_CLS_B       1
`define SCA_CLS_C       2
`define SCA_FI_512      4'h9
`define SCA_DI_8        4'h4
`define SCA_DI_16       4'h5
`define SCA_DI_64       4'h7
`define SCA_FD_DEFAULT  8'h11

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define SCA_BAD_MAX     2'h3
`define SCA_ETU_DEFAULT 9'h174
`define SCA_RST_LOW_LCLK 10'h190
`define SCA_ATR_DELAY   10'h190

`endif

// ==== shared/sca_pkg.sv ====
// types and class helpers for the link setup ends
// assumes: sca_params.svh on the include path
`include "sca_params.svh"

package sca_pkg;

	typedef logic [2:0] sca_cls_t;

	typedef enum logic [2:0] {
		T_IDLE   = 3'b000,
		T_COLD   = 3'b001,
		T_ATR    = 3'b010,
		T_OFF    = 3'b011,
		T_READY  = 3'b100,
		T_REJECT = 3'b101
	} sca_tstate_t;

	typedef enum logic [2:0] {
		P_TS   = 3'b000,
		P_IF   = 3'b001,
		P_HIST = 3'b010,
		P_TCK  = 3'b011,
		P_END  = 3'b100
	} sca_phase_t;

	typedef enum logic [1:0] {
		C_OFF  = 2'b00,
		C_WAIT = 2'b01,
		C_ATR  = 2'b10,
		C_RUN  = 2'b11
	} sca_cstate_t;

	typedef enum logic [1:0] {
		CMD_SELECT    = 2'b00,
		CMD_STATUS    = 2'b01,
		CMD_VERIFY_OK = 2'b10,
		CMD_APP       = 2'b11
	} sca_cmd_t;

	typedef struct packed {
		logic       tx_busy;
		logic [8:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic       rx_busy;
		logic [8:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] rx_data;
		logic       rx_valid;
	} sca_ser_t;

	typedef struct packed {
		sca_tstate_t st;
		sca_cls_t    cls;
		sca_cls_t    vcc;
		logic [1:0]  tries;
		logic [19:0] tmr;
		logic [7:0]  div;
		logic        lclk;
		logic        rst_pin;
		logic        io_s1;
		logic        io_s2;
		sca_phase_t  ph;
		logic [3:0]  pend;
		logic [2:0]  lvl;
		logic [3:0]  k;
		logic        tck_need;
		logic        in15;
		logic        cls_seen;
		sca_cls_t    card_cls;
		logic [7:0]  ta1;
		logic [7:0]  xacc;
		logic        got;
		logic        bad;
		logic        pps_needed;
	} sca_term_t;

	typedef struct packed {
		sca_cstate_t st;
		logic [9:0]  cnt;
		logic [3:0]  idx;
		logic [7:0]  xacc;
		logic        sel;
		logic        lclk_s1;
		logic        lclk_s2;
		logic        lclk_s3;
		logic        rst_s1;
		logic        rst_s2;
		logic        io_s1;
		logic        io_s2;
		logic        pwr_s1;
		logic        pwr_s2;
	} sca_card_t;

	// lowest voltage class of a mask (class c is lowest)
	function automatic sca_cls_t lowest_class(input sca_cls_t m);
		if (m[`SCA_CLS_C])
			return 3'h4;
		else if (m[`SCA_CLS_B])
			return 3'h2;
		else if (m[`SCA_CLS_A])
			return 3'h1;
		return 3'h0;
	endfunction: lowest_class

	// next higher voltage class, zero above class a
	function automatic sca_cls_t next_higher(input sca_cls_t c);
		return c >> 1;
	endfunction: next_higher

	// gapped set collapses to its lowest class
	function automatic sca_cls_t adjacent_set(input sca_cls_t m);
		return (m == 3'h5) ? lowest_class(m) : m;
	endfunction: adjacent_set

	// rate pair acceptable without negotiation
	function automatic logic fd_ok(input logic [7:0] fd, input logic di64);
		return fd == `SCA_FD_DEFAULT ||
			(fd[7:4] == `SCA_FI_512 && (fd[3:0] == `SCA_DI_8 || fd[3:0] == `SCA_DI_16)) ||
			(di64 && fd == {`SCA_FI_512, `SCA_DI_64});
	endfunction: fd_ok

endpackage: sca_pkg

// ==== sim/sca_link_checker.sv ====
// assertions on the link between the two ends
// assumes: beside sca_if, link half period 4 clk
`timescale 1ns/100ps
module sca_link_checker (
	input wire logic clk, // clock
	input wire logic arst_n, // reset
	input wire logic lclk, // link clock
	input wire logic rst, // card reset
	input wire logic [2:0] vcc, // class
	input wire logic io_t_oe_n, // term drive
	input wire logic io_c_oe_n, // card drive
	input wire logic io // io level
);
	// ----------
	// checks
	// ----------
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	a_one_class: assert property ($onehot0(vcc)) else $error("class");
	a_switch_off: assert property ($changed(vcc) |-> !vcc || !$past(vcc)) else $error("switch");
	a_rst_low: assert property ($rose(|vcc) |-> !rst) else $error("rst");
	a_card_quiet: assert property ((!rst) [*4] |-> io_c_oe_n) else $error("card io");
	a_term_quiet: assert property (!rst |-> io_t_oe_n) else $error("term io");
	a_io_idle: assert property ((vcc == 3'h0) [*4] |-> io) else $error("io");
	a_lclk_off: assert property ((vcc == 3'h0) [*3] |-> !lclk) else $error("lclk");
	a_lclk_half: assert property ($rose(lclk) |-> (lclk || vcc == 3'h0) [*4] ##1 !lclk) else $error("half");
endmodule: sca_link_checker

// ==== sim/tb_supply_class_atr_setup.sv ====
// bench joining terminal and card ends
// assumes: short waits, card classes b and c
`timescale 1ns/100ps
module tb_supply_class_atr_setup;
	// ----------
	// bench
	// ----------
	bit clk, arst_n, start, stop, cmd_valid, app_has_ac, mute, truncate, term_tx_valid, card_tx_valid;
	bit [7:0] term_tx_data, card_tx_data;
	logic rx_valid, ready, pps_needed, high_power, rejected, atr_done, term_tx_ready, card_tx_ready, card_rx_valid;
	logic [7:0] rx_data, fd, card_rx_data, got [16];
	logic [7:0] exp_b [10] = '{8'h3b, 8'h97, 8'h94, 8'h80, 8'h1f, 8'h06, 8'h80, 8'h31, 8'ha0, 8'h73};
	sca_pkg::sca_cmd_t cmd_kind = sca_pkg::CMD_SELECT;
	sca_pkg::sca_cls_t cls_used, card_classes;
	int num_errors, n_compared, nb, cyc, n;
	sca_if lnk ();
	sca_term #(.ETU(9'h8), .ATR_WAIT_CLKS(10000), .CHAR_WAIT_CLKS(2000), .OFF_CLKS(50)) sca_term_inst (.clk, .arst_n,
		.lnk(lnk.term), .start, .stop, .tx_data(term_tx_data), .tx_valid(term_tx_valid), .tx_ready(term_tx_ready),
		.rx_data, .rx_valid, .ready, .rejected, .cls_used, .card_classes, .fd, .pps_needed);
	sca_card #(.ETU(9'h8)) sca_card_inst (.clk, .arst_n, .lnk(lnk.card), .cmd_valid, .cmd_kind, .app_has_ac, .mute,
		.truncate, .tx_data(card_tx_data), .tx_valid(card_tx_valid), .tx_ready(card_tx_ready),
		.rx_data(card_rx_data), .rx_valid(card_rx_valid), .atr_done, .high_power);
	sca_link_checker sca_link_checker_inst (.clk, .arst_n, .lclk(lnk.lclk), .rst(lnk.rst), .vcc(lnk.vcc),
		.io_t_oe_n(lnk.io_t_oe_n), .io_c_oe_n(lnk.io_c_oe_n), .io(lnk.io));
	// clock
	initial forever #5 clk = ~clk;
	// answer bytes at the terminal
	always @(posedge clk) if (rx_valid === 1'h1 && nb < 16) begin
		got[nb] <= rx_data;
		nb <= nb + 1;
	end
	// hang guard, the scenarios need about 81k cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000)
			wrap_up(1);
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: %h %h", $time, g, e);
		end
	endtask: chk
	task wrap_up(input int extra);
		num_errors += extra;
		$display("%0d checks, %0d wrong", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask: wrap_up
	task cmd(input logic [1:0] k, input logic [7:0] hp);
		@(posedge clk) #1 cmd_kind = sca_pkg::sca_cmd_t'(k);
		cmd_valid = 1'h1;
		@(posedge clk) #1 cmd_valid = 1'h0;
		chk({7'h0, high_power}, hp);
	endtask: cmd
	task t_retry;
		mute = 1'h1;
		@(posedge clk) #1 start = 1'h1;
		@(posedge clk) #1 start = 1'h0;
		chk({5'h0, lnk.vcc}, 8'h04);
		wait (lnk.vcc === 3'h2);
		#1 mute = 1'h0;
		truncate = 1'h1;
		while (lnk.vcc !== 3'h1) begin
			@(posedge lnk.rst) #1;
			n += (lnk.vcc === 3'h2);
		end
		truncate = 1'h0;
		chk(n[7:0], 8'h03);
		$display("retry done");
	endtask: t_retry
	task t_class_fix;
		wait (lnk.vcc === 3'h4);
		#1 nb = 0;
		wait (ready === 1'h1);
		#1 chk({5'h0, cls_used}, 8'h04);
		chk(fd, 8'h94);
		chk({7'h0, pps_needed}, 8'h00);
		chk({5'h0, card_classes}, 8'h06);
		chk({7'h0, atr_done}, 8'h01);
		foreach (exp_b[i])
			chk(got[i], exp_b[i]);
		$display("class fix done");
	endtask: t_class_fix
	task t_power;
		cmd(2'h0, 8'h00);
		cmd(2'h1, 8'h00);
		cmd(2'h3, 8'h01);
		cmd(2'h0, 8'h00);
		app_has_ac = 1'h1;
		cmd(2'h3, 8'h00);
		cmd(2'h2, 8'h01);
		$display("power done");
	endtask: t_power
	// one byte each way, then deactivation
	task t_link;
		@(posedge clk) #1 card_tx_data = 8'ha5;
		card_tx_valid = 1'h1;
		do @(posedge clk); while (card_tx_ready !== 1'h1);
		#1 card_tx_valid = 1'h0;
		do @(posedge clk); while (rx_valid !== 1'h1);
		chk(rx_data, 8'ha5);
		do @(posedge clk); while (card_tx_ready !== 1'h1);
		#1 term_tx_data = 8'h5a;
		term_tx_valid = 1'h1;
		do @(posedge clk); while (term_tx_ready !== 1'h1);
		#1 term_tx_valid = 1'h0;
		do @(posedge clk); while (card_rx_valid !== 1'h1);
		chk(card_rx_data, 8'h5a);
		@(posedge clk) #1 stop = 1'h1;
		@(posedge clk) #1 stop = 1'h0;
		chk({3'h0, ready, rejected, lnk.vcc}, 8'h00);
		repeat (4) @(posedge clk);
		#1 chk({7'h0, high_power}, 8'h00);
		$display("link done");
	endtask: t_link
	// reset, then the scenarios
	initial begin
		repeat (12) @(posedge clk);
		#1 arst_n = 1'h1;
		t_retry;
		t_class_fix;
		t_power;
		t_link;
		wrap_up(0);
	end
endmodule: tb_supply_class_atr_setup
